/* File: rrs_pkg.sv */
// Shared constants and carrier types for the return, rotate and sleep execution block.
// Assumes a single core clock domain and a classic Wishbone register port with 32-bit data.
package rrs_pkg;

	// ==========================================================
	// Widths
	localparam int PC_W = 13;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int WB_ADR_W = 4;
	localparam int WB_DAT_W = 32;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [WB_ADR_W-1:0] OFS_CTRL = 4'h0;
	localparam logic [WB_ADR_W-1:0] OFS_STATUS = 4'h4;
	localparam logic [WB_ADR_W-1:0] OFS_WREG = 4'h8;
	localparam logic [WB_ADR_W-1:0] OFS_RESULT = 4'hc;

	// Control register fields.
	localparam int CTRL_CARRY_BIT = 0;
	localparam int CTRL_WAKE_BIT = 1;

	// Status register fields.
	localparam int STAT_CARRY_BIT = 0;
	localparam int STAT_TIMEOUT_N_BIT = 1;
	localparam int STAT_POWERDOWN_N_BIT = 2;
	localparam int STAT_SLEEP_BIT = 3;
	localparam int STAT_BUSY_BIT = 4;

	// ==========================================================
	// Operand encodings and reset values
	localparam logic DEST_W = 1'b0;
	localparam logic DEST_F = 1'b1;
	localparam logic CARRY_RST = 1'b0;
	localparam logic FLAG_N_RST = 1'b1;
	localparam logic [DATA_W-1:0] W_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST = 13'h0000;
	localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;
	localparam logic [WB_DAT_W-1:0] RD_ZERO = 32'h0000_0000;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {OP_NONE, OP_RETURN, OP_ROTL, OP_ROTR, OP_SLEEP} op_t;

	typedef enum logic [1:0] {PH_IDLE, PH_RET, PH_SLEEP} phase_t;

	typedef struct packed {
		op_t op;
		logic [FADDR_W-1:0] fileAddr;
		logic dest;
	} instr_t;

	typedef struct packed {
		logic stackPop;
		logic pcLoad;
		logic [PC_W-1:0] pcValue;
	} pc_load_t;

	typedef struct packed {
		logic wr;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} file_wr_t;

	typedef struct packed {
		logic counterClear;
		logic prescalerClear;
	} wdt_ctl_t;

endpackage : rrs_pkg

/* File: return_rotate_sleep_exec.sv */
// Execution unit for return-from-subroutine, rotate left/right through carry and sleep entry.
// Assumes the decoder presents one instruction with its file operand already read, and that
// the stack, file registers and watchdog outside act on the one-cycle strobes driven here.
// Functional notes
// (RULE_01) Return pops the stack and loads the top value into the program counter, leaving all flags alone.
// (RULE_02) Return takes two instruction cycles, so the next fetch starts from the restored counter.
// (RULE_03) Rotate left shifts the file operand toward the top bit through carry and changes only carry.
// (RULE_04) Rotate left writes the accumulator when the destination select is 0 and the file register when 1.
// (RULE_05) Rotate right shifts the file operand toward bit 0 through carry and changes only carry.
// (RULE_06) Rotate right writes the accumulator when the destination select is 0 and the file register when 1.
// (RULE_07) Sleep clears the active-low power-down flag to 0.
// (RULE_08) Sleep sets the active-low time-out flag to 1.
// (RULE_09) Sleep clears the watchdog counter and its prescaler.
// (RULE_10) After those updates sleep halts the core with the oscillator stopped.
// (RULE_11) Left rotate moves old carry into bit 0 and old bit 7 into carry; right rotate the mirror image.
// (RULE_12) Both rotates take one word and one instruction cycle with a seven-bit file operand.
`timescale 1ns/1ps

module return_rotate_sleep_exec
	import rrs_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [WB_DAT_W-1:0] wb_dat_i,
	output logic [WB_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Instruction issue.
	input wire logic instrValid,
	input wire instr_t instr,
	output logic instrReady,
	input wire logic [DATA_W-1:0] fileRdData,
	input wire logic [PC_W-1:0] stackTopValue,
	input wire logic wakeEvent,
	// Core side effects.
	output pc_load_t pcOut,
	output file_wr_t fileWr,
	output logic wWrite,
	output logic [DATA_W-1:0] wOut,
	output logic carryFlag,
	output logic timeoutStatusFlagN,
	output logic powerdownStatusFlagN,
	output wdt_ctl_t watchdogCounterCtl,
	output logic oscStop
);

	// ==========================================================
	// State

	typedef struct packed {
		phase_t phase;
		logic [DATA_W-1:0] w;
		logic carry;
		logic toN;
		logic pdN;
		pc_load_t pc;
		file_wr_t fw;
		logic wWr;
		logic [DATA_W-1:0] result;
		wdt_ctl_t wdt;
		logic ack;
		logic [WB_DAT_W-1:0] rdData;
	} state_t;

	state_t state_reg;
	state_t state_next;

	logic accept;
	logic wbReq;
	logic swWake;
	logic [DATA_W:0] rotLeft;
	logic [DATA_W:0] rotRight;

	// Carry out sits in the top bit, result below it.
	assign rotLeft = {fileRdData, state_reg.carry}; // [RULE_11]
	assign rotRight = {fileRdData[0], state_reg.carry, fileRdData[DATA_W-1:1]}; // [RULE_11]

	assign instrReady = (state_reg.phase == PH_IDLE);
	assign accept = instrValid && instrReady;
	assign wbReq = wb_cyc_i && wb_stb_i && !state_reg.ack;
	assign swWake = wbReq && wb_we_i && wb_sel_i[0] && (wb_adr_i == OFS_CTRL) && wb_dat_i[CTRL_WAKE_BIT];

	// ==========================================================
	// Next state

	always_comb
	begin
		state_next = state_reg;
		state_next.pc.stackPop = 1'b0;
		state_next.pc.pcLoad = 1'b0;
		state_next.fw.wr = 1'b0;
		state_next.wWr = 1'b0;
		state_next.wdt = '0;
		state_next.ack = 1'b0;

		// Bus writes go first so that an instruction in the same cycle has the last word.
		if (wbReq)
		begin
			state_next.ack = 1'b1;
			state_next.rdData = RD_ZERO;
			if (wb_we_i && wb_sel_i[0])
			begin
				case (wb_adr_i)
					OFS_CTRL: state_next.carry = wb_dat_i[CTRL_CARRY_BIT];
					OFS_WREG: state_next.w = wb_dat_i[DATA_W-1:0];
					default: ;
				endcase
			end
			else if (!wb_we_i)
			begin
				case (wb_adr_i)
					OFS_STATUS:
					begin
						state_next.rdData[STAT_CARRY_BIT] = state_reg.carry;
						state_next.rdData[STAT_TIMEOUT_N_BIT] = state_reg.toN;
						state_next.rdData[STAT_POWERDOWN_N_BIT] = state_reg.pdN;
						state_next.rdData[STAT_SLEEP_BIT] = (state_reg.phase == PH_SLEEP);
						state_next.rdData[STAT_BUSY_BIT] = (state_reg.phase == PH_RET);
					end
					OFS_CTRL: state_next.rdData[CTRL_CARRY_BIT] = state_reg.carry;
					OFS_WREG: state_next.rdData[DATA_W-1:0] = state_reg.w;
					OFS_RESULT: state_next.rdData[DATA_W-1:0] = state_reg.result;
					default: ;
				endcase
			end
		end

		case (state_reg.phase)
			PH_IDLE:
			begin
				if (accept)
				begin
					case (instr.op)
						OP_RETURN:
						begin
							// No flag is touched; the wait phase blocks the next fetch.
							state_next.pc.stackPop = 1'b1; // [RULE_01]
							state_next.pc.pcLoad = 1'b1; // [RULE_01]
							state_next.pc.pcValue = stackTopValue; // [RULE_01]
							state_next.phase = PH_RET; // [RULE_02]
						end
						OP_ROTL, OP_ROTR:
						begin
							if (instr.op == OP_ROTL)
							begin
								state_next.result = rotLeft[DATA_W-1:0]; // [RULE_03]
								state_next.carry = rotLeft[DATA_W]; // [RULE_03]
							end
							else
							begin
								state_next.result = rotRight[DATA_W-1:0]; // [RULE_05]
								state_next.carry = rotRight[DATA_W]; // [RULE_05]
							end
							if (instr.dest == DEST_F)
							begin
								state_next.fw.wr = 1'b1; // [RULE_04] [RULE_06]
								state_next.fw.addr = instr.fileAddr; // [RULE_12]
								state_next.fw.data = state_next.result;
							end
							else
							begin
								state_next.wWr = 1'b1; // [RULE_04] [RULE_06]
								state_next.w = state_next.result;
							end
						end
						OP_SLEEP:
						begin
							state_next.pdN = 1'b0; // [RULE_07]
							state_next.toN = 1'b1; // [RULE_08]
							state_next.wdt.counterClear = 1'b1; // [RULE_09]
							state_next.wdt.prescalerClear = 1'b1; // [RULE_09]
							state_next.phase = PH_SLEEP; // [RULE_10]
						end
						default: ;
					endcase
				end
			end
			PH_RET: state_next.phase = PH_IDLE; // [RULE_02]
			PH_SLEEP:
			begin
				// Only a wake source restarts the core; instructions are refused meanwhile.
				if (wakeEvent || swWake)
				begin
					state_next.phase = PH_IDLE;
				end
			end
			default: state_next.phase = PH_IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state_reg.phase <= PH_IDLE;
			state_reg.w <= W_RST;
			state_reg.carry <= CARRY_RST;
			state_reg.toN <= FLAG_N_RST;
			state_reg.pdN <= FLAG_N_RST;
			state_reg.pc <= '{stackPop: 1'b0, pcLoad: 1'b0, pcValue: PC_RST};
			state_reg.fw <= '{wr: 1'b0, addr: FADDR_RST, data: W_RST};
			state_reg.wWr <= 1'b0;
			state_reg.result <= W_RST;
			state_reg.wdt <= '0;
			state_reg.ack <= 1'b0;
			state_reg.rdData <= RD_ZERO;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs

	assign wb_dat_o = state_reg.rdData;
	assign wb_ack_o = state_reg.ack;
	assign pcOut = state_reg.pc;
	assign fileWr = state_reg.fw;
	assign wWrite = state_reg.wWr;
	assign wOut = state_reg.w;
	assign carryFlag = state_reg.carry;
	assign timeoutStatusFlagN = state_reg.toN;
	assign powerdownStatusFlagN = state_reg.pdN;
	assign watchdogCounterCtl = state_reg.wdt;
	assign oscStop = (state_reg.phase == PH_SLEEP); // [RULE_10]

	// ==========================================================
	// Checks

	default clocking chkClk @(posedge core_clk);
	endclocking
	default disable iff (reset);

	chk_return_pop_load: assert property ( // [RULE_01]
		accept && instr.op == OP_RETURN |=> pcOut.stackPop && pcOut.pcLoad && pcOut.pcValue == $past(stackTopValue))
		else $error("return did not pop and load the counter");

	chk_return_flags_kept: assert property ( // [RULE_01]
		accept && instr.op == OP_RETURN && !wbReq |=> $stable(carryFlag) && $stable(timeoutStatusFlagN)
			&& $stable(powerdownStatusFlagN))
		else $error("return changed a status flag");

	chk_return_two_cycles: assert property ( // [RULE_02]
		accept && instr.op == OP_RETURN |=> !instrReady ##1 instrReady && !pcOut.pcLoad)
		else $error("return did not take two cycles");

	chk_rotl_value: assert property ( // [RULE_03]
		accept && instr.op == OP_ROTL |=> carryFlag == $past(fileRdData[DATA_W-1])
			&& (fileWr.wr ? fileWr.data : wOut) == {$past(fileRdData[DATA_W-2:0]), $past(state_reg.carry)})
		else $error("left rotate result or carry wrong");

	chk_rotl_dest_w: assert property ( // [RULE_04]
		accept && instr.op == OP_ROTL && instr.dest == DEST_W |=> wWrite && !fileWr.wr)
		else $error("left rotate with select 0 did not go to the accumulator");

	chk_rotr_value: assert property ( // [RULE_05] [RULE_11]
		accept && instr.op == OP_ROTR |=> carryFlag == $past(fileRdData[0])
			&& (fileWr.wr ? fileWr.data : wOut) == {$past(state_reg.carry), $past(fileRdData[DATA_W-1:1])})
		else $error("right rotate result or carry wrong");

	chk_rotr_dest_f: assert property ( // [RULE_06]
		accept && instr.op == OP_ROTR && instr.dest == DEST_F |=> fileWr.wr && !wWrite
			&& fileWr.addr == $past(instr.fileAddr))
		else $error("right rotate with select 1 did not go to the file register");

	chk_sleep_pd_clear: assert property ( // [RULE_07]
		accept && instr.op == OP_SLEEP |=> !powerdownStatusFlagN)
		else $error("sleep left power-down flag high");

	chk_sleep_to_set: assert property ( // [RULE_08]
		accept && instr.op == OP_SLEEP |=> timeoutStatusFlagN)
		else $error("sleep left time-out flag low");

	chk_sleep_wdt_clear: assert property ( // [RULE_09]
		accept && instr.op == OP_SLEEP |=> watchdogCounterCtl.counterClear && watchdogCounterCtl.prescalerClear
			##1 !watchdogCounterCtl.counterClear)
		else $error("sleep did not pulse the watchdog clears");

	chk_sleep_halts: assert property ( // [RULE_10]
		accept && instr.op == OP_SLEEP |=> oscStop && !instrReady)
		else $error("sleep did not halt the core");

	chk_rotate_one_cycle: assert property ( // [RULE_12]
		accept && (instr.op == OP_ROTL || instr.op == OP_ROTR) |=> instrReady)
		else $error("rotate took more than one cycle");

	chk_rotl_dest_f: assert property ( // [RULE_04]
		accept && instr.op == OP_ROTL && instr.dest == DEST_F |=> fileWr.wr && !wWrite
			&& fileWr.addr == $past(instr.fileAddr))
		else $error("left rotate with select 1 did not go to the file register");

	chk_rotr_dest_w: assert property ( // [RULE_06]
		accept && instr.op == OP_ROTR && instr.dest == DEST_W |=> wWrite && !fileWr.wr)
		else $error("right rotate with select 0 did not go to the accumulator");

	chk_rotate_flags_kept: assert property ( // [RULE_03] [RULE_05]
		accept && (instr.op == OP_ROTL || instr.op == OP_ROTR) |=> $stable(timeoutStatusFlagN)
			&& $stable(powerdownStatusFlagN))
		else $error("rotate changed a flag other than carry");

endmodule : return_rotate_sleep_exec

/* File: tb_return_rotate_sleep_exec.sv */
// Self-checking bench for the return, rotate and sleep execution block.
// Assumes rrs_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
	begin checksDone++; if ((got) !== (exp)) begin mismatches++; \
	$display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end

module tb_return_rotate_sleep_exec
	import rrs_pkg::*;
;
	typedef struct packed {
		op_t op;
		logic dest;
		logic cin;
		logic [DATA_W-1:0] d;
		logic [DATA_W-1:0] r;
		logic cout;
	} row_t;

	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [WB_ADR_W-1:0] wb_adr_i = 4'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [WB_DAT_W-1:0] wb_dat_i = 32'h0;
	logic [WB_DAT_W-1:0] wb_dat_o;
	logic wb_ack_o;
	logic instrValid = 1'b0;
	instr_t instr = '0;
	logic instrReady;
	logic [DATA_W-1:0] fileRdData = 8'h00;
	logic [PC_W-1:0] stackTopValue = 13'h1a5c;
	logic wakeEvent = 1'b0;
	pc_load_t pcOut;
	file_wr_t fileWr;
	logic wWrite;
	logic [DATA_W-1:0] wOut;
	logic carryFlag;
	logic timeoutStatusFlagN;
	logic powerdownStatusFlagN;
	wdt_ctl_t watchdogCounterCtl;
	logic oscStop;
	int mismatches = 0;
	int checksDone = 0;
	int cycleCount = 0;
	logic [WB_DAT_W-1:0] rd;
	row_t rows [0:3];

	return_rotate_sleep_exec return_rotate_sleep_exec_i (.core_clk(core_clk), .reset(reset),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.instrValid(instrValid), .instr(instr), .instrReady(instrReady), .fileRdData(fileRdData),
		.stackTopValue(stackTopValue), .wakeEvent(wakeEvent), .pcOut(pcOut), .fileWr(fileWr),
		.wWrite(wWrite), .wOut(wOut), .carryFlag(carryFlag), .timeoutStatusFlagN(timeoutStatusFlagN),
		.powerdownStatusFlagN(powerdownStatusFlagN), .watchdogCounterCtl(watchdogCounterCtl), .oscStop(oscStop));

	always #12.5 core_clk = ~core_clk;

	// ==========================================================
	// Closing report and hang guard
	task automatic stop_test();
		if (mismatches == 0 && checksDone > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	always @(posedge core_clk)
	begin
		cycleCount++;
		if (cycleCount == 4000)
		begin
			mismatches++;
			stop_test();
		end
	end

	// ==========================================================
	// Bus and instruction drivers
	// The master waits for ack with no bound, then checks a latency of two cycles; only the bench timeout ends a dead wait.
	task automatic wbXfer(input logic we, input logic [WB_ADR_W-1:0] adr, input logic [WB_DAT_W-1:0] dat);
		int n;
		n = 0;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'h1;
		wb_dat_i <= dat;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (wb_ack_o !== 1'b1);
		`CHK("ack latency", 2, n)
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wbXfer

	task automatic issue(input op_t o, input logic [FADDR_W-1:0] a, input logic d, input logic [DATA_W-1:0] f);
		@(posedge core_clk);
		instrValid <= 1'b1;
		instr <= {o, a, d};
		fileRdData <= f;
		@(posedge core_clk);
		instrValid <= 1'b0;
		#1;
	endtask : issue

	// ==========================================================
	// Main sequence
	initial
	begin
		rows[0] = '{OP_ROTL, DEST_W, 1'b0, 8'he6, 8'hcc, 1'b1};
		rows[1] = '{OP_ROTL, DEST_F, 1'b1, 8'h35, 8'h6b, 1'b0};
		rows[2] = '{OP_ROTR, DEST_W, 1'b1, 8'h01, 8'h80, 1'b1};
		rows[3] = '{OP_ROTR, DEST_F, 1'b0, 8'he6, 8'h73, 1'b0};
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		wbXfer(1'b0, OFS_STATUS, 32'h0);
		`CHK("status reset", 32'h0000_0006, rd)
		wbXfer(1'b0, 4'h2, 32'h0);
		`CHK("unmapped read", RD_ZERO, rd)
		wbXfer(1'b1, OFS_WREG, 32'hffff_ff5a);
		wbXfer(1'b0, OFS_WREG, 32'h0);
		`CHK("wreg read", 32'h0000_005a, rd)
		foreach (rows[i])
		begin
			wbXfer(1'b1, OFS_CTRL, {31'h0, rows[i].cin});
			issue(rows[i].op, 7'h7f, rows[i].dest, rows[i].d);
			`CHK("carry", rows[i].cout, carryFlag)
			`CHK("acc write", ~rows[i].dest, wWrite)
			`CHK("file write", rows[i].dest, fileWr.wr)
			if (rows[i].dest == DEST_W)
				`CHK("acc value", rows[i].r, wOut)
			else
			begin
				`CHK("file value", rows[i].r, fileWr.data)
				`CHK("file addr", 7'h7f, fileWr.addr)
			end
			`CHK("one cycle", 1'b1, instrReady)
			`CHK("pd flag kept", 1'b1, powerdownStatusFlagN)
		end
		wbXfer(1'b0, OFS_RESULT, 32'h0);
		`CHK("result read", 32'h0000_0073, rd)
		wbXfer(1'b1, OFS_CTRL, 32'h0000_0001);
		wbXfer(1'b0, OFS_CTRL, 32'h0);
		`CHK("ctrl read", 32'h0000_0001, rd)
		issue(OP_RETURN, 7'h00, 1'b0, 8'h00);
		`CHK("pop", 1'b1, pcOut.stackPop)
		`CHK("pc load", 1'b1, pcOut.pcLoad)
		`CHK("pc value", 13'h1a5c, pcOut.pcValue)
		`CHK("ret busy", 1'b0, instrReady)
		`CHK("ret carry", 1'b1, carryFlag)
		@(posedge core_clk);
		#1;
		`CHK("ret done", 1'b1, instrReady)
		`CHK("pc pulse", 1'b0, pcOut.pcLoad)
		issue(OP_SLEEP, 7'h00, 1'b0, 8'h00);
		`CHK("pd clear", 1'b0, powerdownStatusFlagN)
		`CHK("to set", 1'b1, timeoutStatusFlagN)
		`CHK("wdt clear", 2'b11, watchdogCounterCtl)
		`CHK("osc stop", 1'b1, oscStop)
		`CHK("halted", 1'b0, instrReady)
		wbXfer(1'b0, OFS_STATUS, 32'h0);
		`CHK("status sleep", 32'h0000_000b, rd)
		`CHK("wdt pulse", 2'b00, watchdogCounterCtl)
		`CHK("still asleep", 1'b1, oscStop)
		wakeEvent <= 1'b1;
		@(posedge core_clk);
		wakeEvent <= 1'b0;
		#1;
		`CHK("woken", 1'b0, oscStop)
		issue(OP_SLEEP, 7'h00, 1'b0, 8'h00);
		wbXfer(1'b1, OFS_CTRL, 32'h0000_0002);
		#1;
		`CHK("bus wake", 1'b0, oscStop)
		`CHK("ready again", 1'b1, instrReady)
		// A bus write of carry in the cycle a rotate is taken must lose to the rotate.
		fork
			wbXfer(1'b1, OFS_CTRL, 32'h0000_0001);
			issue(OP_ROTL, 7'h11, DEST_W, 8'h40);
		join
		#1;
		`CHK("rotate over bus", 1'b0, carryFlag)
		`CHK("rotate acc", 8'h80, wOut)
		issue(OP_NONE, 7'h00, 1'b0, 8'h00);
		`CHK("none acc", 1'b0, wWrite)
		`CHK("none file", 1'b0, fileWr.wr)
		`CHK("none ready", 1'b1, instrReady)
		// A reset in mid-run must restore the active-low flags after a sleep cleared one.
		reset <= 1'b1;
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		`CHK("pd after reset", 1'b1, powerdownStatusFlagN)
		`CHK("osc after reset", 1'b0, oscStop)
		stop_test();
	end
endmodule : tb_return_rotate_sleep_exec
